// file: core/codec_pkg.sv
package codec_pkg;

  // Code-group and nibble widths
  localparam int NIB_W = 4;
  localparam int CG_W  = 5;

  // Control code-groups
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0d;
  localparam logic [4:0] CG_R    = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;

  // Nibbles presented on the receive side
  localparam logic [3:0] NIB_ZERO    = 4'h0;
  localparam logic [3:0] NIB_SSD     = 4'h5;
  localparam logic [3:0] NIB_INV_DEF = 4'h6;
  localparam logic [3:0] NIB_INV_ALT = 4'h5;

  // Serializer bit counter and buffer
  localparam logic [2:0] SER_FIRST = 3'h0;
  localparam logic [2:0] SER_LAST  = 3'h4;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_FULL  = 2'h2;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mii_tx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mii_rx_s;

  // Two alternately phased streams for the line driver
  typedef struct packed {
    logic pos;
    logic neg;
  } pair_transmit_outputs_s;

endpackage

// file: core/fe_4b5b_mlt3_codec.sv
`timescale 1ns/1ps
// Overview of operation
// - Data nibbles map to fixed 5-bit groups
// - Idle is 11111, decodes to 0000
// - J=11000, K=10001, both decode to 0101
// - T=01101, R=00111, both decode to 0000
// - Halt code-group is 00100
// - Ten unused 5-bit patterns are invalid
// - Invalid group gives nibble 6h with error
// - Select bit set gives 5h, still error
// - Control groups other than T inside data are invalid
// - TX_EN with TX_ER sends Halt groups
// - Delimiters stay intact during error substitution
// - Split MLT-3 into two alternating one streams
// - Transmit pair outputs carry only MLT-3
// - First preamble byte replaced by J/K
// - On enable drop send T/R, then idle
module fe_4b5b_mlt3_codec (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  // MII transmit
  input  wire codec_pkg::mii_tx_s               mii_tx,
  output logic                                  tx_ready,
  // MII receive
  output codec_pkg::mii_rx_s                    mii_rx,
  // Aligned receive code-groups
  input  wire logic [codec_pkg::CG_W-1:0]       rx_cg,
  input  wire logic                             rx_cg_valid,
  // Configuration
  input  wire logic                             code_err_sel,
  // Line driver
  output codec_pkg::pair_transmit_outputs_s     pair_transmit_outputs
);

  function automatic logic [4:0] enc_nib(input logic [3:0] n);
    logic [4:0] c;
    c = codec_pkg::CG_IDLE;
    unique case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      4'hf: c = 5'h1d;
    endcase
    return c;
  endfunction

  // Returns {is_data, nibble}; anything not a data group is reported as not data
  function automatic logic [4:0] dec_cg(input logic [4:0] c);
    logic [4:0] r;
    r = {1'b0, codec_pkg::NIB_ZERO};
    for (int i = 0; i < 16; i++) begin
      if (enc_nib(i[3:0]) == c) begin
        r = {1'b1, i[3:0]};
      end
    end
    return r;
  endfunction

  // ---------------- Transmit encoder ----------------
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_K    = 4'b0010,
    TX_DATA = 4'b0100,
    TX_R    = 4'b1000
  } tx_state_e;

  tx_state_e  tx_st_q;
  tx_state_e  tx_st_d;
  logic [4:0] enc_cg;
  logic       buf_in_ready;
  logic       push;

  assign tx_ready = buf_in_ready & (tx_st_q != TX_R);
  assign push     = buf_in_ready;

  always_comb begin
    tx_st_d = tx_st_q;
    enc_cg  = codec_pkg::CG_IDLE;
    unique case (tx_st_q)
      TX_IDLE: begin
        if (mii_tx.en) begin
          enc_cg  = codec_pkg::CG_J;
          tx_st_d = TX_K;
        end
      end
      TX_K: begin
        enc_cg  = codec_pkg::CG_K;
        tx_st_d = TX_DATA;
      end
      TX_DATA: begin
        if (!mii_tx.en) begin
          enc_cg  = codec_pkg::CG_T;
          tx_st_d = TX_R;
        end else if (mii_tx.er) begin
          enc_cg  = codec_pkg::CG_HALT;
        end else begin
          enc_cg  = enc_nib(mii_tx.d);
        end
      end
      TX_R: begin
        enc_cg  = codec_pkg::CG_R;
        tx_st_d = TX_IDLE;
      end
    endcase
  end

  // Encoder only advances when the buffer takes the group, so a stall loses nothing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q <= TX_IDLE;
    end else if (push) begin
      tx_st_q <= tx_st_d;
    end
  end

  // ---------------- Two-entry buffer ----------------
  logic [4:0] buf_mem [2];
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic [1:0] cnt_q;
  logic       buf_out_valid;
  logic       pop;
  logic       load;

  assign buf_in_ready  = (cnt_q != codec_pkg::BUF_FULL);
  assign buf_out_valid = (cnt_q != codec_pkg::BUF_EMPTY);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_mem[wr_ptr_q] <= enc_cg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= codec_pkg::BUF_EMPTY;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      cnt_q    <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  // ---------------- Serializer, NRZI, MLT-3 ----------------
  typedef enum logic [3:0] {
    MLT_ZERO_A = 4'b0001,
    MLT_POS    = 4'b0010,
    MLT_ZERO_B = 4'b0100,
    MLT_NEG    = 4'b1000
  } mlt_state_e;

  logic [4:0] sh_q;
  logic [2:0] bit_cnt_q;
  logic       nrzi_q;
  logic       nrzi_d;
  mlt_state_e mlt_q;
  mlt_state_e mlt_d;
  logic       ser_bit;

  assign load    = (bit_cnt_q == codec_pkg::SER_LAST);
  assign pop     = load & buf_out_valid;
  assign ser_bit = sh_q[codec_pkg::CG_W-1];
  assign nrzi_d  = nrzi_q ^ ser_bit;

  // A one in the bit stream is a transition of the NRZI line; each steps the level
  always_comb begin
    mlt_d = mlt_q;
    if (nrzi_d != nrzi_q) begin
      unique case (mlt_q)
        MLT_ZERO_A: mlt_d = MLT_POS;
        MLT_POS:    mlt_d = MLT_ZERO_B;
        MLT_ZERO_B: mlt_d = MLT_NEG;
        MLT_NEG:    mlt_d = MLT_ZERO_A;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q      <= codec_pkg::CG_IDLE;
      bit_cnt_q <= codec_pkg::SER_FIRST;
      nrzi_q    <= 1'b0;
      mlt_q     <= MLT_ZERO_A;
    end else begin
      // An empty buffer at load time fills the line with idle
      sh_q      <= load ? (buf_out_valid ? buf_mem[rd_ptr_q] : codec_pkg::CG_IDLE) : sh_q << 1;
      bit_cnt_q <= load ? codec_pkg::SER_FIRST : bit_cnt_q + 3'h1;
      nrzi_q    <= nrzi_d;
      mlt_q     <= mlt_d;
    end
  end

  // Only MLT-3 reaches the pair; no binary mode exists
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_transmit_outputs <= '0;
    end else begin
      pair_transmit_outputs.pos <= (mlt_d == MLT_POS);
      pair_transmit_outputs.neg <= (mlt_d == MLT_NEG);
    end
  end

  // ---------------- Receive decoder ----------------
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_K    = 4'b0010,
    RX_DATA = 4'b0100,
    RX_R    = 4'b1000
  } rx_state_e;

  rx_state_e          rx_st_q;
  rx_state_e          rx_st_d;
  codec_pkg::mii_rx_s rx_d;
  logic [4:0]         dec;
  logic [3:0]         inv_nib;
  codec_pkg::mii_rx_s inv_word;

  assign dec      = dec_cg(rx_cg);
  assign inv_nib  = code_err_sel ? codec_pkg::NIB_INV_ALT : codec_pkg::NIB_INV_DEF;
  assign inv_word = '{dv: 1'b1, er: 1'b1, d: inv_nib};

  always_comb begin
    rx_st_d = rx_st_q;
    rx_d    = '{dv: 1'b0, er: 1'b0, d: codec_pkg::NIB_ZERO};
    unique case (rx_st_q)
      RX_IDLE: begin
        if (rx_cg == codec_pkg::CG_J) begin
          rx_d    = '{dv: 1'b1, er: 1'b0, d: codec_pkg::NIB_SSD};
          rx_st_d = RX_K;
        end else if (!dec[4] && rx_cg != codec_pkg::CG_IDLE) begin
          rx_d    = '{dv: 1'b0, er: 1'b1, d: inv_nib};
        end
      end
      RX_K: begin
        if (rx_cg == codec_pkg::CG_K) begin
          rx_d    = '{dv: 1'b1, er: 1'b0, d: codec_pkg::NIB_SSD};
          rx_st_d = RX_DATA;
        end else begin
          rx_d    = inv_word;
          rx_st_d = RX_IDLE;
        end
      end
      RX_DATA: begin
        if (dec[4]) begin
          rx_d = '{dv: 1'b1, er: 1'b0, d: dec[3:0]};
        end else if (rx_cg == codec_pkg::CG_T) begin
          rx_d    = '{dv: 1'b0, er: 1'b0, d: codec_pkg::NIB_ZERO};
          rx_st_d = RX_R;
        end else begin
          rx_d = inv_word;
        end
      end
      RX_R: begin
        rx_st_d = RX_IDLE;
        if (rx_cg != codec_pkg::CG_R) begin
          rx_d = '{dv: 1'b0, er: 1'b1, d: inv_nib};
        end else begin
          rx_d = '{dv: 1'b0, er: 1'b0, d: codec_pkg::NIB_ZERO};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_q <= RX_IDLE;
      mii_rx  <= '0;
    end else if (rx_cg_valid) begin
      rx_st_q <= rx_st_d;
      mii_rx  <= rx_d;
    end
  end

endmodule // fe_4b5b_mlt3_codec

// file: sim/mac_model.sv
`timescale 1ns/1ps
module mac_model (
  // Clock
  input  wire logic          sys_clk,
  // Transmit handshake
  input  wire logic          tx_ready,
  output codec_pkg::mii_tx_s mii_tx
);
  initial mii_tx = '0;

  // Nibble stays put until an edge finds ready high
  task automatic put(input logic en, input logic er, input logic [3:0] d);
    logic r;
    mii_tx <= '{en: en, er: er && en, d: d};
    do begin
      @(negedge sys_clk);
      r = tx_ready;
      @(posedge sys_clk);
    end while (!r);
  endtask
endmodule // mac_model

// file: sim/fe_4b5b_mlt3_codec_asserts.sv
`timescale 1ns/1ps
module codec_asserts (
  // Clock and reset
  input wire logic                              sys_clk,
  input wire logic                              arst_n,
  // Watched ports
  input wire codec_pkg::mii_tx_s                mii_tx,
  input wire logic                              tx_ready,
  input wire codec_pkg::mii_rx_s                mii_rx,
  input wire logic [4:0]                        rx_cg,
  input wire logic                              rx_cg_valid,
  input wire logic                              code_err_sel,
  input wire codec_pkg::pair_transmit_outputs_s pair_transmit_outputs
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic       last_pos_q;
  wire        pos = pair_transmit_outputs.pos;
  wire        neg = pair_transmit_outputs.neg;
  wire        inv = rx_cg_valid && (rx_cg inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19});
  wire [3:0]  inv_nib = code_err_sel ? codec_pkg::NIB_INV_ALT : codec_pkg::NIB_INV_DEF;
  wire        take_i = rx_cg_valid && rx_cg == codec_pkg::CG_IDLE;
  wire        take_j = rx_cg_valid && rx_cg == codec_pkg::CG_J;
  wire        take_k = rx_cg_valid && rx_cg == codec_pkg::CG_K;
  wire        take_t = rx_cg_valid && rx_cg == codec_pkg::CG_T;
  wire        take_r = rx_cg_valid && rx_cg == codec_pkg::CG_R;
  wire        take_d0 = rx_cg_valid && rx_cg == 5'h1e;
  logic [3:0] ready_low_q;

  // Full buffer allows one take per group; the R slot adds one more group of wait
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) ready_low_q <= 4'h0;
    else if (tx_ready) ready_low_q <= 4'h0;
    else if (ready_low_q != 4'hf) ready_low_q <= ready_low_q + 4'h1;

  // Remembers the sign of the last nonzero line level
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) last_pos_q <= 1'b0;
    else if (pos || neg) last_pos_q <= pos;

  line_levels_a: assert property (!(pos && neg)) else $error("both pair outputs high");
  plus_step_a: assert property ($rose(pos) |-> !last_pos_q) else $error("plus not after minus");
  minus_step_a: assert property ($rose(neg) |-> last_pos_q) else $error("minus not after plus");
  invalid_map_a: assert property (inv |=> mii_rx.er && mii_rx.d == $past(inv_nib))
    else $error("invalid group mapping wrong");
  // An open frame keeps dv high, so dv low proves the decoder is outside the data field
  idle_out_a: assert property (!mii_rx.dv && take_i ##1 take_i |=> mii_rx == 6'h00)
    else $error("idle decode wrong");
  start_pair_a: assert property (!mii_rx.dv && take_i ##1 take_j |=> mii_rx == 6'h25)
    else $error("J decode wrong");
  data_decode_a: assert property (!mii_rx.dv && take_i ##1 take_j ##1 take_k ##1 take_d0 |=> mii_rx == 6'h20)
    else $error("data decode wrong");
  ctrl_in_data_a: assert property (!mii_rx.dv && take_i ##1 take_j ##1 take_k ##1 take_j
    |=> mii_rx.dv && mii_rx.er) else $error("control group in data not flagged");
  end_pair_a: assert property (take_t ##1 take_r |=> !mii_rx.dv) else $error("valid after end pair");
  ready_gap_a: assert property (ready_low_q <= 4'h9) else $error("transmit ready held low too long");

  cover property (inv);
  cover property ($rose(neg));
  cover property (mii_rx.dv && mii_rx.er);
endmodule // codec_asserts

bind fe_4b5b_mlt3_codec codec_asserts u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .mii_tx(mii_tx),
  .tx_ready(tx_ready), .mii_rx(mii_rx), .rx_cg(rx_cg), .rx_cg_valid(rx_cg_valid),
  .code_err_sel(code_err_sel), .pair_transmit_outputs(pair_transmit_outputs));

// file: sim/fe_4b5b_mlt3_codec_tb.sv
`timescale 1ns/1ps
module fe_4b5b_mlt3_codec_tb;
  logic                              sys_clk;
  logic                              arst_n;
  codec_pkg::mii_tx_s                mii_tx;
  codec_pkg::mii_rx_s                mii_rx;
  codec_pkg::pair_transmit_outputs_s pair_transmit_outputs;
  logic                              tx_ready;
  logic [4:0]                        rx_cg;
  logic                              rx_cg_valid;
  logic                              code_err_sel;
  int                                err_count;
  int                                check_count;
  logic [5:0]                        pend;
  bit                                has;
  logic [1:0]                        lvl_q = '0;
  logic [9:0]                        sr = '0;
  int                                cnt;
  bit                                inf;
  bit                                done;
  logic [4:0]                        got[$];
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] VCG [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};

  fe_4b5b_mlt3_codec i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .mii_tx(mii_tx), .tx_ready(tx_ready),
    .mii_rx(mii_rx), .rx_cg(rx_cg), .rx_cg_valid(rx_cg_valid), .code_err_sel(code_err_sel),
    .pair_transmit_outputs(pair_transmit_outputs));
  mac_model u_mac (.sys_clk(sys_clk), .tx_ready(tx_ready), .mii_tx(mii_tx));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Line decoder: a level change is a one; groups framed from the J/K pair
  always @(posedge sys_clk) begin
    sr = {sr[8:0], pair_transmit_outputs != lvl_q};
    lvl_q = pair_transmit_outputs;
    if (inf) begin
      cnt++;
      if (cnt == 5) begin
        got.push_back(sr[4:0]);
        cnt = 0;
        if (sr[4:0] == codec_pkg::CG_R) begin
          inf = 0;
          done = 1;
        end
      end
    end else if (sr == {codec_pkg::CG_J, codec_pkg::CG_K}) begin
      inf = 1;
      cnt = 0;
    end
  end

  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Result of each group is judged one call later, once it is registered
  task automatic rx(input logic [4:0] cg, input logic [5:0] exp);
    @(posedge sys_clk);
    rx_cg <= cg;
    rx_cg_valid <= 1'b1;
    @(negedge sys_clk);
    if (has) chk(mii_rx, pend);
    pend = exp;
    has = 1;
  endtask

  task automatic rx_flush;
    @(posedge sys_clk);
    rx_cg_valid <= 1'b0;
    @(negedge sys_clk);
    chk(mii_rx, pend);
    has = 0;
  endtask

  task automatic tx_frame(input bit er_on);
    logic [4:0] e;
    got.delete();
    done = 0;
    @(posedge sys_clk);
    u_mac.put(1, 0, 4'h5);
    u_mac.put(1, 0, 4'h5);
    for (int i = 0; i < 16; i++) u_mac.put(1, er_on && i > 3 && i < 8, i[3:0]);
    u_mac.put(0, 0, 4'h0);
    for (int n = 0; n < 300 && !done; n++) @(posedge sys_clk);
    chk(6'(got.size()), 6'h12);
    for (int i = 0; i < 16; i++) begin
      e = (er_on && i > 3 && i < 8) ? codec_pkg::CG_HALT : ENC[i];
      chk({1'b0, got[i]}, {1'b0, e});
    end
    chk({got[16], 1'b0}, {codec_pkg::CG_T, 1'b0});
    chk({got[17], 1'b0}, {codec_pkg::CG_R, 1'b0});
    repeat (12) @(posedge sys_clk);
    chk({sr[9:5] == 5'h1f, sr[4:0]}, 6'h3f);
  endtask

  task automatic rx_table;
    rx(codec_pkg::CG_IDLE, 6'h00);
    rx(codec_pkg::CG_IDLE, 6'h00);
    rx(codec_pkg::CG_J, 6'h25);
    rx(codec_pkg::CG_K, 6'h25);
    for (int i = 0; i < 16; i++) rx(ENC[i], {2'b10, i[3:0]});
    rx(codec_pkg::CG_T, 6'h00);
    rx(codec_pkg::CG_R, 6'h00);
    rx(codec_pkg::CG_IDLE, 6'h00);
  endtask

  task automatic rx_bad;
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      code_err_sel <= s[0];
      for (int v = 0; v < 10; v++) begin
        rx(VCG[v], s ? 6'h15 : 6'h16);
        rx(codec_pkg::CG_IDLE, 6'h00);
      end
    end
    rx(codec_pkg::CG_J, 6'h25);
    rx(codec_pkg::CG_K, 6'h25);
    rx(codec_pkg::CG_J, 6'h35);
    rx_flush();
  endtask

  initial begin
    arst_n = 1'b0;
    rx_cg = '0;
    rx_cg_valid = 1'b0;
    code_err_sel = 1'b0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    tx_frame(0);
    tx_frame(1);
    rx_table();
    rx_bad();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
endmodule // fe_4b5b_mlt3_codec_tb
